/* logic/iststr_top.sv */
/*
 * Instrument status and trigger block: standard event status with enable,
 * operation and questionable register sets, error queue, summary status
 * byte and trigger unit loading preset levels into the active setpoints.
 * Assumes the command decoder gives one-cycle read/write strobes with a
 * register selector, and event pulses from the same clock. The external
 * trigger line is asynchronous and active low.
 */
// Functional notes
// - Event bit 0 sets on operation complete or query results ready.
// - Event bits 1 and 6 always read zero.
// - Event bit 2 on query error, bit 3 on device-dependent error.
// - Event bit 4 on execution error, bit 5 on command error.
// - Event bit 7 sets at power-up; summary needs enable bit 7.
// - Host reads and writes enable mask; mask gates event summary.
// - Transition filters are fixed rising-edge; host writes ignored.
// - Operation bit 5 high while waiting for trigger.
// - Operation bit 8 in constant voltage, bit 10 in constant current.
// - Operation bit 14 high while a stored program runs.
// - Unused operation condition bits read zero.
// - Questionable bit 0 overvoltage, bit 1 overcurrent.
// - Questionable bit 2 lead connection, bit 3 thermal error.
// - Questionable bit 4 mains, bit 5 fan, bit 6 master/slave.
// - Questionable bits 7 to 15 read zero.
// - Errors queue first-in first-out; empty read returns zero.
// - Over fifteen errors keep oldest; last entry becomes code -350.
// - Triggers accepted only from the selected source.
// - External grounding copies preset levels into active setpoints.
// - Calibration or model-limit change resets presets to minimum.
// - Software trigger from trigger command or group execute message.
// - Rising condition edges latch into events; reading clears them.
// - Events join the summary only where enable bits are one.
// - Status byte bits 2,3,4,5,7: queue, questionable, message, event, operation.
`default_nettype none
module iststr_top
    import iststr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Register port from the command decoder.
    input  wire iststr_pkg::iststr_sel_t reg_sel,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [ISTSTR_DW-1:0] reg_wdata,
    output logic      [ISTSTR_DW-1:0] reg_rdata,
    // Standard event sources, one-cycle pulses.
    input  wire logic                 op_complete,
    input  wire logic                 query_error,
    input  wire logic                 device_error,
    input  wire logic                 execution_error,
    input  wire logic                 command_error,
    input  wire logic                 message_available,
    // Error queue push.
    input  wire logic                 error_push,
    input  wire logic [ISTSTR_EW-1:0] error_code,
    // Operation condition sources, levels.
    input  wire logic                 const_voltage,
    input  wire logic                 const_current,
    input  wire logic                 program_running,
    // Questionable condition sources, levels.
    input  wire logic [Q_USED-1:0]    fault_flags,
    // Trigger inputs.
    input  wire logic                 trigger_armed,
    input  wire logic                 external_trigger_line_n,
    input  wire logic                 sw_trigger_cmd,
    input  wire logic                 group_execute_trigger,
    input  wire logic                 calibration_done,
    input  wire logic                 model_limits_changed,
    // Active setpoints and status byte.
    output logic      [ISTSTR_DW-1:0] voltage_setpoint,
    output logic      [ISTSTR_DW-1:0] current_setpoint,
    output logic                      trigger_event,
    output logic      [7:0]           summary_status_byte
);
    import iststr_pkg::*;

    logic [7:0]  sevt_r, sevt_nxt, sen_r, sen_nxt;
    logic [15:0] open_r, open_nxt, qena_r, qena_nxt;
    logic [15:0] vtrig_r, vtrig_nxt, ctrig_r, ctrig_nxt;
    logic [15:0] vset_r, vset_nxt, cset_r, cset_nxt;
    logic        tsrc_hw_r, tsrc_hw_nxt;
    logic [2:0]  ext_r, ext_nxt;
    logic [15:0] op_cond, q_cond, op_evt, q_evt, rdata;
    logic        trig, ext_fall, sw_trig, esb, errq_ne;
    logic [15:0] errq_head;
    logic        rd_sevt, rd_opevt, rd_qevt, rd_op, rd_q, pop_q;

    // Read strobes of the clear-on-read and pop-on-read registers.
    assign rd_sevt  = reg_rd && reg_sel == ISTSTR_SEL_SEVT;
    assign rd_op    = reg_rd && reg_sel == ISTSTR_SEL_OPCOND;
    assign rd_opevt = reg_rd && reg_sel == ISTSTR_SEL_OPEVT || rd_op;
    assign rd_q     = reg_rd && reg_sel == ISTSTR_SEL_QCOND;
    assign rd_qevt  = reg_rd && reg_sel == ISTSTR_SEL_QEVT || rd_q;
    assign pop_q    = reg_rd && reg_sel == ISTSTR_SEL_ERRQ;

    // Condition registers; unused bits are tied low.
    always_comb begin
        op_cond = '0;
        op_cond[OP_WTRIG] = trigger_armed;
        op_cond[OP_CV] = const_voltage;
        op_cond[OP_CC] = const_current;
        op_cond[OP_PROG] = program_running;
        q_cond = '0;
        q_cond[Q_USED-1:0] = fault_flags;
    end

    // Operation and questionable event latches.
    iststr_edge #(.W(16)) u_op_evt (
        .clk  (clk),
        .srst (srst),
        .cond (op_cond),
        .clr  (rd_opevt),
        .evt  (op_evt)
    );
    iststr_edge #(.W(16)) u_q_evt (
        .clk  (clk),
        .srst (srst),
        .cond (q_cond),
        .clr  (rd_qevt),
        .evt  (q_evt)
    );

    // Error queue.
    iststr_errq u_errq (
        .clk       (clk),
        .srst      (srst),
        .push      (error_push),
        .code      (error_code),
        .pop       (pop_q),
        .head      (errq_head),
        .not_empty (errq_ne)
    );

    // External trigger synchroniser and falling-edge detector.
    assign ext_nxt  = {ext_r[1:0], external_trigger_line_n};
    assign ext_fall = ext_r[2] && !ext_r[1];
    assign sw_trig  = sw_trigger_cmd || group_execute_trigger;
    assign trig     = tsrc_hw_r ? ext_fall : sw_trig;

    // Next values of the standard event and control registers.
    always_comb begin
        sevt_nxt = rd_sevt ? 8'h00 : sevt_r;
        sevt_nxt[SEVT_OPC] = sevt_nxt[SEVT_OPC] | op_complete
            | message_available;
        sevt_nxt[SEVT_QYE] = sevt_nxt[SEVT_QYE] | query_error;
        sevt_nxt[SEVT_DDE] = sevt_nxt[SEVT_DDE] | device_error;
        sevt_nxt[SEVT_EXE] = sevt_nxt[SEVT_EXE] | execution_error;
        sevt_nxt[SEVT_CME] = sevt_nxt[SEVT_CME] | command_error;
        sevt_nxt[SEVT_RQC] = 1'b0;
        sevt_nxt[SEVT_URQ] = 1'b0;
        sen_nxt   = sen_r;
        open_nxt  = open_r;
        qena_nxt  = qena_r;
        tsrc_hw_nxt = tsrc_hw_r;
        vtrig_nxt = vtrig_r;
        ctrig_nxt = ctrig_r;
        if (reg_wr) begin
            case (reg_sel)
                ISTSTR_SEL_SEN:   sen_nxt = reg_wdata[7:0];
                ISTSTR_SEL_OPENA: open_nxt = reg_wdata;
                ISTSTR_SEL_QENA:  qena_nxt = reg_wdata;
                ISTSTR_SEL_TSRC:  tsrc_hw_nxt = reg_wdata[0];
                ISTSTR_SEL_VTRIG: vtrig_nxt = reg_wdata;
                ISTSTR_SEL_CTRIG: ctrig_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (calibration_done || model_limits_changed) begin
            vtrig_nxt = LEVEL_MIN;
            ctrig_nxt = LEVEL_MIN;
        end
        vset_nxt = trig ? vtrig_r : vset_r;
        cset_nxt = trig ? ctrig_r : cset_r;
    end

    // Registers; reset is the power-up event that sets bit 7.
    always_ff @(posedge clk) begin
        if (srst) begin
            sevt_r    <= SEVT_RST;
            sen_r     <= SEN_RST;
            open_r    <= ENA_RST;
            qena_r    <= ENA_RST;
            tsrc_hw_r <= 1'b0;
            vtrig_r   <= LEVEL_MIN;
            ctrig_r   <= LEVEL_MIN;
            vset_r    <= LEVEL_MIN;
            cset_r    <= LEVEL_MIN;
            ext_r     <= 3'h7;
            reg_rdata <= '0;
        end else begin
            sevt_r    <= sevt_nxt;
            sen_r     <= sen_nxt;
            open_r    <= open_nxt;
            qena_r    <= qena_nxt;
            tsrc_hw_r <= tsrc_hw_nxt;
            vtrig_r   <= vtrig_nxt;
            ctrig_r   <= ctrig_nxt;
            vset_r    <= vset_nxt;
            cset_r    <= cset_nxt;
            ext_r     <= ext_nxt;
            reg_rdata <= rdata;
        end
    end

    // Summary status byte from masked events, plus queue not-empty and message available.
    assign esb = |(sevt_r & sen_r);
    always_comb begin
        summary_status_byte = 8'h00;
        summary_status_byte[SSB_ERRQ] = errq_ne;
        summary_status_byte[SSB_QUES] = |(q_evt & qena_r);
        summary_status_byte[SSB_MAV]  = message_available;
        summary_status_byte[SSB_ESUM] = esb;
        summary_status_byte[SSB_OPER] = |(op_evt & open_r);
    end

    // Read multiplexer; the transition filters always read fixed.
    always_comb begin
        case (reg_sel)
            ISTSTR_SEL_SEVT:   rdata = {8'h00, sevt_r};
            ISTSTR_SEL_SEN:    rdata = {8'h00, sen_r};
            ISTSTR_SEL_OPCOND: rdata = op_cond;
            ISTSTR_SEL_OPEVT:  rdata = op_evt;
            ISTSTR_SEL_OPENA:  rdata = open_r;
            ISTSTR_SEL_OPTRN:  rdata = TRN_FIXED;
            ISTSTR_SEL_QCOND:  rdata = q_cond;
            ISTSTR_SEL_QEVT:   rdata = q_evt;
            ISTSTR_SEL_QENA:   rdata = qena_r;
            ISTSTR_SEL_QTRN:   rdata = TRN_FIXED;
            ISTSTR_SEL_SSB:    rdata = {8'h00, summary_status_byte};
            ISTSTR_SEL_ERRQ:   rdata = errq_head;
            ISTSTR_SEL_TSRC:   rdata = {15'h0000, tsrc_hw_r};
            ISTSTR_SEL_VTRIG:  rdata = vtrig_r;
            ISTSTR_SEL_CTRIG:  rdata = ctrig_r;
            default:           rdata = 16'h0000;
        endcase
    end

    assign voltage_setpoint = vset_r;
    assign current_setpoint = cset_r;
    assign trigger_event    = trig;

    sequence s_ext_fall;
        tsrc_hw_r && ext_r[2] && !ext_r[1];
    endsequence
    AST_EXT_LOADS: assert property (@(posedge clk) disable iff (srst)
        s_ext_fall |=> vset_r == $past(vtrig_r)
            && cset_r == $past(ctrig_r))
        else $error("External trigger did not load setpoints.");
    AST_SRC_SELECT: assert property (@(posedge clk) disable iff (srst)
        (!tsrc_hw_r && !sw_trigger_cmd && !group_execute_trigger)
            |-> !trigger_event)
        else $error("Trigger taken from unselected source.");
    AST_SW_TRIG: assert property (@(posedge clk) disable iff (srst)
        (!tsrc_hw_r && sw_trigger_cmd) |-> trigger_event)
        else $error("Software trigger ignored.");
    AST_SEVT_ZERO: assert property (@(posedge clk) disable iff (srst)
        !sevt_r[SEVT_RQC] && !sevt_r[SEVT_URQ])
        else $error("Unused event bits set.");
    AST_ERR_STICK: assert property (@(posedge clk) disable iff (srst)
        command_error ##1 !rd_sevt |=> sevt_r[SEVT_CME])
        else $error("Command error not held.");
    AST_PON_MASK: assert property (@(posedge clk) disable iff (srst)
        (sevt_r == 8'h80 && !sen_r[SEVT_PON])
            |-> !summary_status_byte[SSB_ESUM])
        else $error("Masked power-on reached summary.");
    AST_OP_ZERO: assert property (@(posedge clk) disable iff (srst)
        (op_cond & 16'hbadf) == 16'h0000)
        else $error("Unused operation bits set.");
    AST_PRESET_RST: assert property (@(posedge clk) disable iff (srst)
        calibration_done |=> vtrig_r == LEVEL_MIN && ctrig_r == LEVEL_MIN)
        else $error("Presets not reset to minimum.");
endmodule
`default_nettype wire

/* logic/iststr_pkg.sv */
/*
 * Package of the instrument status and trigger block: register selectors,
 * bit positions, widths, reset values and error codes.
 * Assumes a single 250 MHz clock domain and a synchronous reset.
 */
`default_nettype none
package iststr_pkg;
    // Register selectors of the command register port.
    typedef enum logic [3:0] {
        ISTSTR_SEL_SEVT,   // Standard event status, clear on read.
        ISTSTR_SEL_SEN,    // Standard event enable mask.
        ISTSTR_SEL_OPCOND, // Operation condition.
        ISTSTR_SEL_OPEVT,  // Operation event, clear on read.
        ISTSTR_SEL_OPENA,  // Operation enable mask.
        ISTSTR_SEL_OPTRN,  // Operation transition filter, fixed.
        ISTSTR_SEL_QCOND,  // Questionable condition.
        ISTSTR_SEL_QEVT,   // Questionable event, clear on read.
        ISTSTR_SEL_QENA,   // Questionable enable mask.
        ISTSTR_SEL_QTRN,   // Questionable transition filter, fixed.
        ISTSTR_SEL_SSB,    // Summary status byte.
        ISTSTR_SEL_ERRQ,   // Error queue, pop on read.
        ISTSTR_SEL_TSRC,   // Trigger source select.
        ISTSTR_SEL_VTRIG,  // Preset voltage trigger level.
        ISTSTR_SEL_CTRIG   // Preset current trigger level.
    } iststr_sel_t;

    localparam int ISTSTR_DW = 16;
    localparam int ISTSTR_EW = 16;
    localparam int ISTSTR_QDEPTH = 15;
    localparam int ISTSTR_QAW = 4;
    // Standard event status bit positions.
    localparam int SEVT_OPC = 0;
    localparam int SEVT_RQC = 1;
    localparam int SEVT_QYE = 2;
    localparam int SEVT_DDE = 3;
    localparam int SEVT_EXE = 4;
    localparam int SEVT_CME = 5;
    localparam int SEVT_URQ = 6;
    localparam int SEVT_PON = 7;
    // Operation condition bit positions.
    localparam int OP_WTRIG = 5;
    localparam int OP_CV = 8;
    localparam int OP_CC = 10;
    localparam int OP_PROG = 14;
    // Questionable condition bits used: 0..6.
    localparam int Q_USED = 7;
    // Status byte bit positions.
    localparam int SSB_ERRQ = 2;
    localparam int SSB_QUES = 3;
    localparam int SSB_MAV = 4;
    localparam int SSB_ESUM = 5;
    localparam int SSB_OPER = 7;
    // Reset values and the fixed transition filter read value.
    localparam logic [7:0]  SEN_RST = 8'h00;
    localparam logic [15:0] ENA_RST = 16'h0000;
    localparam logic [7:0]  SEVT_RST = 8'h80;
    localparam logic [15:0] TRN_FIXED = 16'hffff;
    localparam logic [15:0] LEVEL_MIN = 16'h0000;
    // Error codes, two's complement.
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_OVERFLOW = 16'hfea2; // -350
endpackage
`default_nettype wire

/* logic/iststr_edge.sv */
/*
 * Rising-edge latch of one event register with clear-on-read.
 * Assumes condition inputs are already in the clock domain.
 */
`default_nettype none
module iststr_edge #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] cond,
    input  wire logic         clr,
    output logic      [W-1:0] evt
);
    logic [W-1:0] prev_r, prev_nxt, evt_r, evt_nxt;

    // Set wins over clear so that an edge in the reading cycle survives.
    always_comb begin
        prev_nxt = cond;
        evt_nxt  = (clr ? '0 : evt_r) | (cond & ~prev_r);
    end

    // Registers the condition history and the event bits.
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_r <= '0;
            evt_r  <= '0;
        end else begin
            prev_r <= prev_nxt;
            evt_r  <= evt_nxt;
        end
    end

    assign evt = evt_r;
endmodule
`default_nettype wire

/* logic/iststr_errq.sv */
/*
 * Error queue of fifteen entries; on overflow the newest error is
 * dropped and the last slot becomes the too-many-errors code.
 * Assumes push and pop are single-cycle pulses from the same clock.
 */
`default_nettype none
module iststr_errq
    import iststr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 push,
    input  wire logic [ISTSTR_EW-1:0] code,
    input  wire logic                 pop,
    output logic      [ISTSTR_EW-1:0] head,
    output logic                      not_empty
);
    logic [ISTSTR_EW-1:0] mem_r [ISTSTR_QDEPTH];
    logic [ISTSTR_EW-1:0] mem_nxt [ISTSTR_QDEPTH];
    logic [ISTSTR_QAW-1:0] cnt_r, cnt_nxt;
    logic [ISTSTR_QAW-1:0] wi;

    // Shifts on pop; pushes at the tail; overflow rewrites the last slot.
    always_comb begin
        wi = '0;
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        if (pop && cnt_r != '0) begin
            for (int i = 0; i < ISTSTR_QDEPTH - 1; i++) begin
                mem_nxt[i] = mem_r[i+1];
            end
            cnt_nxt = cnt_r - 4'h1;
        end
        if (push) begin
            if (cnt_nxt < 4'(ISTSTR_QDEPTH)) begin
                wi = cnt_nxt;
                mem_nxt[wi] = code;
                cnt_nxt = cnt_nxt + 4'h1;
            end else begin
                mem_nxt[ISTSTR_QDEPTH-1] = ERR_OVERFLOW;
            end
        end
    end

    // Registers the queue storage and fill count.
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
            for (int i = 0; i < ISTSTR_QDEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign head = (cnt_r == '0) ? ERR_NONE : mem_r[0];
    assign not_empty = (cnt_r != '0);

    AST_ERRQ_FULL_KEEP: assert property (@(posedge clk) disable iff (srst)
        (cnt_r == 4'hf && push && !pop) |=> (cnt_r == 4'hf)
            && mem_r[14] == ERR_OVERFLOW && $stable(mem_r[0]))
        else $error("Overflow did not keep oldest and mark last entry.");
    AST_ERRQ_EMPTY_ZERO: assert property (@(posedge clk) disable iff (srst)
        (cnt_r == 4'h0) |-> head == ERR_NONE)
        else $error("Empty queue did not read no-error.");
endmodule
`default_nettype wire

/* testbench/iststr_host.sv */
/*
 * Host-side model: issues register writes and reads over the command
 * register port and grounds the external trigger line on request.
 * Assumes the block takes one-cycle strobes sampled at the rising edge.
 */
`default_nettype none
module iststr_host
    import iststr_pkg::*;
(
    input  wire logic                             clk,
    output iststr_pkg::iststr_sel_t               reg_sel,
    output logic                                  reg_wr,
    output logic                                  reg_rd,
    output logic      [iststr_pkg::ISTSTR_DW-1:0] reg_wdata,
    output logic                                  ext_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus and a released line, which its pull-up holds high.
    initial begin
        reg_sel = ISTSTR_SEL_SEVT;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        ext_n = 1'b1;
    end

    // One write strobe; selector and data stand for the whole cycle.
    task automatic wr(input iststr_sel_t s, input logic [15:0] d);
        @(posedge clk);
        reg_sel <= s;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One read strobe; the answer shows after the taking edge.
    task automatic rd(input iststr_sel_t s);
        @(posedge clk);
        reg_sel <= s;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // Grounds the trigger line for n cycles, then lets it float high.
    task automatic pull(input int n);
        @(posedge clk);
        ext_n <= 1'b0;
        repeat (n) @(posedge clk);
        ext_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/*
 * Self-checking bench of the status and trigger block: read answers are
 * noted in a queue and checked by a monitor; status byte and setpoints
 * are checked directly. Assumes a 250 MHz clock and synchronous reset.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import iststr_pkg::*;

    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic        [8:0] pl = 9'h000;
    logic              mav = 1'b0;
    logic              push = 1'b0;
    logic       [15:0] code = 16'h0000;
    logic        [3:0] opc = 4'h0;
    logic        [6:0] flt = 7'h00;
    iststr_sel_t       reg_sel;
    logic              reg_wr;
    logic              reg_rd;
    logic              ext_n;
    logic              trig;
    logic              rd_d = 1'b0;
    logic       [15:0] reg_wdata;
    logic       [15:0] reg_rdata;
    logic       [15:0] vset;
    logic       [15:0] cset;
    logic       [15:0] v;
    logic       [15:0] c;
    logic        [7:0] ssb;
    logic       [16:0] e17;
    logic       [16:0] exp_q[$];
    int                error_cnt = 0;
    int                checks_done = 0;
    int                trg_cnt = 0;
    int                seed = 32'h4ec1d04c;

    // Clock of 4 ns period.
    always #2 clk = ~clk;

    iststr_host u_iststr_host (
        .clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .ext_n(ext_n)
    );

    iststr_top u_iststr_top (
        .clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .op_complete(pl[0]), .query_error(pl[1]), .device_error(pl[2]),
        .execution_error(pl[3]), .command_error(pl[4]),
        .message_available(mav), .error_push(push), .error_code(code),
        .const_voltage(opc[1]), .const_current(opc[2]),
        .program_running(opc[3]), .fault_flags(flt),
        .trigger_armed(opc[0]), .external_trigger_line_n(ext_n),
        .sw_trigger_cmd(pl[5]), .group_execute_trigger(pl[6]),
        .calibration_done(pl[7]), .model_limits_changed(pl[8]),
        .voltage_setpoint(vset), .current_setpoint(cset),
        .trigger_event(trig), .summary_status_byte(ssb)
    );

    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Settled status byte bit against its expected level.
    task automatic chk_ssb(input int b, input logic e);
        @(negedge clk);
        cmp(16'(ssb[b]), 16'(e));
    endtask

    // Settled active setpoints against the expected pair.
    task automatic chk_set(input logic [15:0] ev, input logic [15:0] ec);
        @(negedge clk);
        cmp(vset, ev);
        cmp(cset, ec);
    endtask

    // Read with a noted answer, or with the answer ignored.
    task automatic rd(input iststr_sel_t s, input logic [15:0] e);
        exp_q.push_back({1'b1, e});
        u_iststr_host.rd(s);
    endtask

    task automatic rdx(input iststr_sel_t s);
        exp_q.push_back(17'h00000);
        u_iststr_host.rd(s);
    endtask

    // One-cycle pulse on the selected event and trigger inputs.
    task automatic pulse(input logic [8:0] m);
        @(posedge clk);
        pl <= m;
        @(posedge clk);
        pl <= 9'h000;
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Monitor: each read pops the oldest note; noted answers are checked against it.
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d) begin
            e17 = exp_q.pop_front();
            if (e17[16]) cmp(reg_rdata, e17[15:0]);
        end
    end

    // Counts accepted trigger events.
    always @(posedge clk) if (trig === 1'b1) trg_cnt++;

    // Cuts a hang short.
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end

    // Main sequence.
    initial begin
        hold(20);
        srst <= 1'b0;
        chk_ssb(SSB_ESUM, 1'b0);
        u_iststr_host.wr(ISTSTR_SEL_SEN, 16'h0080);
        chk_ssb(SSB_ESUM, 1'b1);
        rd(ISTSTR_SEL_SEN, 16'h0080);
        rd(ISTSTR_SEL_SEVT, 16'h0080);
        rd(ISTSTR_SEL_SEVT, 16'h0000);
        chk_ssb(SSB_ESUM, 1'b0);
        for (int i = 0; i < 5; i++) begin
            pulse(9'h001 << i);
            rd(ISTSTR_SEL_SEVT, 16'h0001 << (i == 0 ? 0 : i + 1));
        end
        pulse(9'h01f);
        rd(ISTSTR_SEL_SEVT, 16'h003d);
        mav <= 1'b1;
        chk_ssb(SSB_MAV, 1'b1);
        rd(ISTSTR_SEL_SEVT, 16'h0001);
        mav <= 1'b0;
        repeat (4) begin
            opc <= 4'($random(seed));
            hold(2);
            rd(ISTSTR_SEL_OPCOND, {1'b0, opc[3], 3'h0, opc[2], 1'b0,
                opc[1], 2'h0, opc[0], 5'h00});
        end
        opc <= 4'h0;
        hold(2);
        rdx(ISTSTR_SEL_OPEVT);
        opc <= 4'h2;
        hold(2);
        chk_ssb(SSB_OPER, 1'b0);
        u_iststr_host.wr(ISTSTR_SEL_OPENA, 16'h0100);
        chk_ssb(SSB_OPER, 1'b1);
        rd(ISTSTR_SEL_OPEVT, 16'h0100);
        u_iststr_host.wr(ISTSTR_SEL_OPTRN, 16'h0000);
        rd(ISTSTR_SEL_OPTRN, TRN_FIXED);
        flt <= 7'($random(seed));
        hold(2);
        rd(ISTSTR_SEL_QCOND, {9'h000, flt});
        flt <= 7'h00;
        hold(2);
        rdx(ISTSTR_SEL_QEVT);
        u_iststr_host.wr(ISTSTR_SEL_QENA, 16'h0001);
        flt <= 7'h41;
        hold(2);
        chk_ssb(SSB_QUES, 1'b1);
        rd(ISTSTR_SEL_QEVT, 16'h0041);
        rd(ISTSTR_SEL_QEVT, 16'h0000);
        u_iststr_host.wr(ISTSTR_SEL_QTRN, 16'h0000);
        rd(ISTSTR_SEL_QTRN, TRN_FIXED);
        rd(ISTSTR_SEL_ERRQ, ERR_NONE);
        for (int i = 1; i <= 16; i++) begin
            @(posedge clk);
            push <= 1'b1;
            code <= 16'(i);
            @(posedge clk);
            push <= 1'b0;
        end
        chk_ssb(SSB_ERRQ, 1'b1);
        for (int i = 1; i <= 14; i++) rd(ISTSTR_SEL_ERRQ, 16'(i));
        rd(ISTSTR_SEL_ERRQ, ERR_OVERFLOW);
        rd(ISTSTR_SEL_ERRQ, ERR_NONE);
        chk_ssb(SSB_ERRQ, 1'b0);
        opc <= 4'h1;
        v = 16'($random(seed));
        c = 16'($random(seed));
        u_iststr_host.wr(ISTSTR_SEL_VTRIG, v);
        u_iststr_host.wr(ISTSTR_SEL_CTRIG, c);
        u_iststr_host.wr(ISTSTR_SEL_TSRC, 16'h0000);
        u_iststr_host.pull(6);
        hold(4);
        chk_set(LEVEL_MIN, LEVEL_MIN);
        pulse(9'h020);
        chk_set(v, c);
        v = 16'($random(seed));
        u_iststr_host.wr(ISTSTR_SEL_VTRIG, v);
        pulse(9'h040);
        chk_set(v, c);
        u_iststr_host.wr(ISTSTR_SEL_VTRIG, ~v);
        u_iststr_host.wr(ISTSTR_SEL_CTRIG, ~c);
        u_iststr_host.wr(ISTSTR_SEL_TSRC, 16'h0001);
        pulse(9'h060);
        chk_set(v, c);
        trg_cnt = 0;
        u_iststr_host.pull(6);
        hold(4);
        chk_set(~v, ~c);
        cmp(16'(trg_cnt), 16'h0001);
        pulse(9'h080);
        rd(ISTSTR_SEL_VTRIG, LEVEL_MIN);
        rd(ISTSTR_SEL_CTRIG, LEVEL_MIN);
        u_iststr_host.wr(ISTSTR_SEL_VTRIG, v);
        pulse(9'h100);
        rd(ISTSTR_SEL_VTRIG, LEVEL_MIN);
        hold(4);
        stop_test();
    end
endmodule
`default_nettype wire
